/* acs_pkg.sv */
// Constants, field layout and tables shared by the conversion sequencer
package acs_pkg;

  // ==========================================================================
  // Clocking
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned MOD_DIV = 4;
  localparam int unsigned MOD_HZ = OSC_HZ / MOD_DIV;
  localparam int OSC_CNT_W = 6;
  localparam int MOD_CNT_W = 2;
  localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_DIV - 1);
  localparam logic [MOD_CNT_W-1:0] MOD_LAST = MOD_CNT_W'(MOD_DIV - 1);

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LSB = 8'h0C;

  // Configuration fields
  localparam int CFG_SS = 15;
  localparam int CFG_MUX_HI = 14;
  localparam int CFG_MUX_LO = 12;
  localparam int CFG_FSR_HI = 11;
  localparam int CFG_FSR_LO = 9;
  localparam int CFG_MODE = 8;
  localparam int CFG_RATE_HI = 7;
  localparam int CFG_RATE_LO = 5;
  localparam int CFG_TEMP = 4;
  localparam logic [2:0] MUX_RST = 3'h0;
  localparam logic [2:0] FSR_RST = 3'h2;
  localparam logic MODE_RST = 1'b1;
  localparam logic [2:0] RATE_RST = 3'h4;
  localparam logic TEMP_RST = 1'b0;

  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_NEW = 1;
  localparam int STAT_PWR = 2;

  // Input selection codes
  localparam logic [2:0] MUX_D01 = 3'h0;
  localparam logic [2:0] MUX_D03 = 3'h1;
  localparam logic [2:0] MUX_D13 = 3'h2;
  localparam logic [2:0] MUX_D23 = 3'h3;
  localparam logic [2:0] MUX_S0 = 3'h4;
  localparam logic [2:0] MUX_S1 = 3'h5;
  localparam logic [2:0] MUX_S2 = 3'h6;
  localparam logic [2:0] MUX_S3 = 3'h7;
  localparam logic [3:0] SEL_IN0 = 4'h1;
  localparam logic [3:0] SEL_IN1 = 4'h2;
  localparam logic [3:0] SEL_IN2 = 4'h4;
  localparam logic [3:0] SEL_IN3 = 4'h8;
  localparam logic [3:0] SEL_NONE = 4'h0;

  // ==========================================================================
  // Result format
  localparam int RES_W = 12;
  localparam int WORD_W = 16;
  localparam int PAD_W = WORD_W - RES_W;
  localparam logic [RES_W-1:0] CODE_MAX = 12'h7FF;
  localparam logic [RES_W-1:0] CODE_MIN = 12'h800;
  localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [PAD_W-1:0] CODE_PAD = 4'h0;
  localparam int ACC_W = 13;
  localparam int RCP_W = 22;
  localparam int PROD_W = ACC_W + RCP_W;
  localparam int RCP_SHIFT = 16;
  localparam logic [ACC_W-1:0] ACC_ZERO = 13'h0000;
  localparam logic [ACC_W-1:0] ACC_STEP = 13'h0001;

  // Modulator samples per conversion, MOD_HZ / data rate
  localparam int unsigned RATE_SPS [0:7] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};
  localparam logic [11:0] SAMPLES [0:7] = '{12'(MOD_HZ / 128), 12'(MOD_HZ / 250), 12'(MOD_HZ / 490),
                                            12'(MOD_HZ / 920), 12'(MOD_HZ / 1600), 12'(MOD_HZ / 2400),
                                            12'(MOD_HZ / 3300), 12'(MOD_HZ / 3300)};
  // Fixed-point reciprocal 2^11 * 2^16 / samples, so no divider is needed
  localparam logic [RCP_W-1:0] RECIP [0:7] = '{22'h10C74, 22'h20C4A, 22'h40404, 22'h78EA4,
                                               22'hD20D2, 22'h13B13B, 22'h1B4E82, 22'h1B4E82};

  // Full-scale range in millivolts per gain code, LSB is twice that over 2^12
  localparam int unsigned FSR_MV [0:7] = '{6144, 4096, 2048, 1024, 512, 256, 256, 256};
  localparam longint unsigned NV_PER_MV = 1_000_000;
  localparam longint unsigned LSB_DIV = 2048;

  function automatic logic [DATA_W-1:0] lsb_nv(input logic [2:0] sel);
    longint unsigned v;
    v = longint'(FSR_MV[sel]) * NV_PER_MV / LSB_DIV;
    return DATA_W'(v);
  endfunction : lsb_nv

endpackage : acs_pkg

/* acs_clock_div.sv */
// Internal oscillator tick and modulator sample tick generator
`timescale 1ns/1ps
`default_nettype none
module acs_clock_div
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Ticks
  output logic oscTick,
  output logic modTick
);

  logic [OSC_CNT_W-1:0] oscCnt_q;
  logic [MOD_CNT_W-1:0] modCnt_q;

  // ==========================================================================
  // Oscillator, then divide by four for the modulator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oscCnt_q <= '0;
      oscTick <= 1'b0;
    end else begin
      oscTick <= (oscCnt_q == OSC_LAST); // [RQ13]
      oscCnt_q <= (oscCnt_q == OSC_LAST) ? '0 : oscCnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modCnt_q <= '0;
      modTick <= 1'b0;
    end else begin
      modTick <= 1'b0;
      if (oscTick) begin
        modTick <= (modCnt_q == MOD_LAST); // [RQ12]
        modCnt_q <= (modCnt_q == MOD_LAST) ? '0 : modCnt_q + 1'b1;
      end
    end
  end

  a_mod_spacing: assert property (@(posedge clk) disable iff (!arst_n) // [RQ12]
    $rose(modTick) |-> ##1 !modTick [*8])
    else $error("modulator tick repeated too early");

endmodule : acs_clock_div
`default_nettype wire

/* acs_sequencer.sv */
// Conversion sequencer: modes, input selection, range, decimation and result register
//
// What this block does
// (RQ1) Single-shot: one conversion per request, result stored in the result register.
// (RQ2) After a single-shot conversion, power down until the next request.
// (RQ3) Continuous: next conversion starts at once when the previous one completes.
// (RQ4) Continuous results come at the rate chosen by the data-rate field.
// (RQ5) Result may be read any time and holds the latest completed conversion.
// (RQ6) Three-bit input field picks four single-ended or two differential inputs.
// (RQ7) Input field also measures inputs zero, one, two against input three.
// (RQ8) Single-ended choice grounds the negative converter input through a mux switch.
// (RQ9) Single-ended measurements never report negative codes.
// (RQ10) Three-bit gain field picks one of six full-scale ranges.
// (RQ11) One code step is full span over two to the twelfth.
// (RQ12) Modulator clock is the 1 MHz oscillator divided by four.
// (RQ13) Runs from the internal oscillator only; rate follows oscillator frequency.
// (RQ14) Temperature-mode bit set to one measures the internal sensor instead.
// (RQ15) Temperature result is 12 bits left-justified in 16, low four unused.
// (RQ16) Result word is presented most significant byte first.
// (RQ17) Temperature step is 0.125 degrees; 25 degrees reads 0C8h.
// (RQ18) Negative temperatures are twos complement; minus 25 reads F38h.
// (RQ19) Mode bit zero means continuous, one means single-shot with power-down.
// (RQ20) Writing one to the request bit powers up, clears it, starts; ignored when busy.
// (RQ21) Results are 12-bit twos complement, left-justified, saturating 7FF0h and 8000h.
// (RQ22) Temperature result uses the same register and the same sequencing.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  // Modulator bitstream from the analog core
  input wire logic modBit,
  // Analog control
  output logic analogPowerUp,
  output logic [3:0] positiveConverterInput,
  output logic [3:0] negativeConverterInput,
  output logic negativeInputGround,
  output logic temperatureSensorSelect,
  output logic [2:0] fullScaleRangeSelect,
  output logic modulatorClock,
  // Conversion events
  output logic conversionDone
);

  typedef enum logic {ST_POWER_DOWN, ST_CONVERT} acs_state_t;

  acs_state_t state_q;
  logic [2:0] muxSel_q;
  logic [2:0] fsrSel_q;
  logic [2:0] rateSel_q;
  logic singleShot_q;
  logic temperatureMode_q;
  logic newData_q;
  logic [WORD_W-1:0] result_q;
  logic [ACC_W-1:0] acc_q;
  logic [11:0] sampCnt_q;
  logic [2:0] convRate_q;
  logic convSingleEnded_q;
  logic oscTick;
  logic modTick;
  logic cfgWrite;
  logic ssRequest;
  logic lastSample;
  logic startConv;
  logic [ACC_W-1:0] accNext;
  logic signed [PROD_W-1:0] product;
  logic signed [PROD_W-1:0] scaled;
  logic [RES_W-1:0] code;
  logic singleEnded;
  logic [2:0] rateNext;
  logic singleEndedNext;

  // ==========================================================================
  // Timing source
  acs_clock_div uDiv (
    .clk(clk),
    .arst_n(arst_n),
    .oscTick(oscTick),
    .modTick(modTick)
  );

  // ==========================================================================
  // Configuration register
  assign cfgWrite = regWrite && (regAddr == OFS_CONFIG);
  // Request only counts while idle; during a conversion it is dropped
  assign ssRequest = cfgWrite && regWrData[CFG_SS] && (state_q == ST_POWER_DOWN); // [RQ20]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      muxSel_q <= MUX_RST;
      fsrSel_q <= FSR_RST;
      singleShot_q <= MODE_RST;
      rateSel_q <= RATE_RST;
      temperatureMode_q <= TEMP_RST;
    end else if (cfgWrite) begin
      muxSel_q <= regWrData[CFG_MUX_HI:CFG_MUX_LO]; // [RQ6]
      fsrSel_q <= regWrData[CFG_FSR_HI:CFG_FSR_LO]; // [RQ10]
      singleShot_q <= regWrData[CFG_MODE]; // [RQ19]
      rateSel_q <= regWrData[CFG_RATE_HI:CFG_RATE_LO]; // [RQ4]
      temperatureMode_q <= regWrData[CFG_TEMP]; // [RQ14]
    end
  end

  // ==========================================================================
  // Sequencer
  assign lastSample = modTick && (state_q == ST_CONVERT) && (sampCnt_q == SAMPLES[convRate_q] - 12'h001);
  // Continuous mode also starts from power-down as soon as it is selected
  assign startConv = ((state_q == ST_POWER_DOWN) && (ssRequest || !singleShot_q)) || // [RQ19]
                     (lastSample && !singleShot_q); // [RQ3]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_POWER_DOWN;
    end else begin
      case (state_q)
        ST_POWER_DOWN: begin
          if (startConv) begin
            state_q <= ST_CONVERT; // [RQ1] [RQ20]
          end
        end
        ST_CONVERT: begin
          if (lastSample && singleShot_q) begin
            state_q <= ST_POWER_DOWN; // [RQ2]
          end
        end
        default: state_q <= ST_POWER_DOWN;
      endcase
    end
  end

  // A request write carries the settings of its own conversion, so take them from the bus
  assign rateNext = cfgWrite ? regWrData[CFG_RATE_HI:CFG_RATE_LO] : rateSel_q;
  assign singleEndedNext = cfgWrite ? (regWrData[CFG_MUX_HI] && !regWrData[CFG_TEMP]) :
                                      (singleEnded && !temperatureMode_q);

  // Rate and input kind are frozen per conversion so a mid-conversion write cannot change the sample count or the clamp
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      convRate_q <= RATE_RST;
      convSingleEnded_q <= 1'b0;
    end else if (startConv) begin
      convRate_q <= rateNext; // [RQ4]
      convSingleEnded_q <= singleEndedNext; // [RQ9]
    end
  end

  // ==========================================================================
  // Decimator: signed count of modulator ones minus zeros over one conversion
  assign accNext = modBit ? acc_q + ACC_STEP : acc_q - ACC_STEP;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= ACC_ZERO;
      sampCnt_q <= '0;
    end else if (startConv) begin
      acc_q <= ACC_ZERO;
      sampCnt_q <= '0;
    end else if (modTick && (state_q == ST_CONVERT)) begin
      acc_q <= accNext;
      sampCnt_q <= sampCnt_q + 12'h001;
    end
  end

  // Reciprocal multiply scales the count to 12 bits whatever the rate
  assign product = PROD_W'($signed(accNext)) * $signed({1'b0, RECIP[convRate_q]});
  assign scaled = product >>> RCP_SHIFT;

  always_comb begin
    if (scaled > PROD_W'($signed({1'b0, CODE_MAX}))) begin
      code = CODE_MAX; // [RQ21]
    end else if (scaled < -PROD_W'($signed({1'b0, CODE_MIN}))) begin
      code = CODE_MIN; // [RQ21]
    end else begin
      code = scaled[RES_W-1:0];
    end
    if (convSingleEnded_q && code[RES_W-1]) begin
      code = CODE_ZERO; // [RQ9]
    end
  end

  // ==========================================================================
  // Result register, shared by analog and temperature conversions
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= '0;
      conversionDone <= 1'b0;
    end else begin
      conversionDone <= lastSample;
      if (lastSample) begin
        // Sensor code arrives already in 0.125 degree steps, twos complement
        result_q <= {code, CODE_PAD}; // [RQ1] [RQ15] [RQ17] [RQ18] [RQ21] [RQ22]
      end
    end
  end

  // Set wins over the clear from a result read in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      newData_q <= 1'b0;
    end else if (lastSample) begin
      newData_q <= 1'b1;
    end else if (regRead && (regAddr == OFS_RESULT)) begin
      newData_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Analog switch control
  assign singleEnded = muxSel_q[2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      positiveConverterInput <= SEL_NONE;
      negativeConverterInput <= SEL_NONE;
      negativeInputGround <= 1'b0;
      temperatureSensorSelect <= 1'b0;
      fullScaleRangeSelect <= FSR_RST;
      analogPowerUp <= 1'b0;
      modulatorClock <= 1'b0;
    end else begin
      analogPowerUp <= (state_q == ST_CONVERT); // [RQ2]
      modulatorClock <= modTick; // [RQ12]
      fullScaleRangeSelect <= fsrSel_q; // [RQ10]
      temperatureSensorSelect <= temperatureMode_q; // [RQ14]
      negativeInputGround <= singleEnded && !temperatureMode_q; // [RQ8]
      if (temperatureMode_q) begin
        positiveConverterInput <= SEL_NONE; // [RQ14]
        negativeConverterInput <= SEL_NONE;
      end else begin
        case (muxSel_q)
          MUX_D01: begin
            positiveConverterInput <= SEL_IN0; // [RQ6]
            negativeConverterInput <= SEL_IN1;
          end
          MUX_D03: begin
            positiveConverterInput <= SEL_IN0; // [RQ7]
            negativeConverterInput <= SEL_IN3;
          end
          MUX_D13: begin
            positiveConverterInput <= SEL_IN1; // [RQ7]
            negativeConverterInput <= SEL_IN3;
          end
          MUX_D23: begin
            positiveConverterInput <= SEL_IN2; // [RQ6] [RQ7]
            negativeConverterInput <= SEL_IN3;
          end
          MUX_S0: begin
            positiveConverterInput <= SEL_IN0; // [RQ6] [RQ8]
            negativeConverterInput <= SEL_NONE;
          end
          MUX_S1: begin
            positiveConverterInput <= SEL_IN1; // [RQ6] [RQ8]
            negativeConverterInput <= SEL_NONE;
          end
          MUX_S2: begin
            positiveConverterInput <= SEL_IN2; // [RQ6] [RQ8]
            negativeConverterInput <= SEL_NONE;
          end
          MUX_S3: begin
            positiveConverterInput <= SEL_IN3; // [RQ6] [RQ8]
            negativeConverterInput <= SEL_NONE;
          end
          default: begin
            positiveConverterInput <= SEL_NONE;
            negativeConverterInput <= SEL_NONE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= '0;
    end else if (regRead) begin
      case (regAddr)
        // Request bit always reads back zero once taken
        OFS_CONFIG: regRdData <= DATA_W'({1'b0, muxSel_q, fsrSel_q, singleShot_q, rateSel_q, temperatureMode_q,
                                          4'h0}); // [RQ20]
        OFS_RESULT: regRdData <= DATA_W'({result_q[WORD_W-1:8], result_q[7:0]}); // [RQ5] [RQ16]
        OFS_STATUS: regRdData <= DATA_W'({analogPowerUp, newData_q, state_q == ST_CONVERT});
        OFS_LSB: regRdData <= lsb_nv(fsrSel_q); // [RQ11]
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_single_done;
    lastSample && singleShot_q;
  endsequence

  sequence s_cont_done;
    lastSample && !singleShot_q;
  endsequence

  a_single_powerdown: assert property (@(posedge clk) disable iff (!arst_n) // [RQ2]
    s_single_done |=> state_q == ST_POWER_DOWN ##1 !analogPowerUp)
    else $error("no power-down after single conversion");

  a_cont_restart: assert property (@(posedge clk) disable iff (!arst_n) // [RQ3]
    s_cont_done |=> state_q == ST_CONVERT && sampCnt_q == 12'h000)
    else $error("continuous mode did not restart");

  a_request_start: assert property (@(posedge clk) disable iff (!arst_n) // [RQ20]
    ssRequest |=> state_q == ST_CONVERT ##1 analogPowerUp)
    else $error("request did not start a conversion");

  a_busy_ignore: assert property (@(posedge clk) disable iff (!arst_n) // [RQ20]
    (state_q == ST_CONVERT && !lastSample && cfgWrite) |=> state_q == ST_CONVERT)
    else $error("write disturbed an active conversion");

  a_result_hold: assert property (@(posedge clk) disable iff (!arst_n) // [RQ5]
    !lastSample |=> $stable(result_q))
    else $error("result changed without a conversion");

  a_result_read: assert property (@(posedge clk) disable iff (!arst_n) // [RQ5]
    (regRead && regAddr == OFS_RESULT && !lastSample) |=> regRdData == DATA_W'(result_q))
    else $error("result read wrong");

  a_low_nibble: assert property (@(posedge clk) disable iff (!arst_n) // [RQ15]
    conversionDone |-> result_q[PAD_W-1:0] == CODE_PAD)
    else $error("low result bits not zero");

  a_single_ended: assert property (@(posedge clk) disable iff (!arst_n) // [RQ9]
    (lastSample && convSingleEnded_q) |=> !result_q[WORD_W-1])
    else $error("negative single-ended code");

  a_ground_switch: assert property (@(posedge clk) disable iff (!arst_n) // [RQ8]
    $changed(muxSel_q) && muxSel_q[2] && !temperatureMode_q |=> negativeInputGround &&
      negativeConverterInput == SEL_NONE)
    else $error("single-ended input not grounded");

  a_saturate_top: assert property (@(posedge clk) disable iff (!arst_n) // [RQ21]
    (lastSample && $signed(accNext) == $signed(PROD_W'(SAMPLES[convRate_q]))) |=>
      result_q == {CODE_MAX, CODE_PAD})
    else $error("positive full scale not clipped");

endmodule : acs_sequencer
`default_nettype wire

/* acs_mod_source.sv */
// Modulator bitstream source standing in for the analog core
`timescale 1ns/1ps
`default_nettype none
module acs_mod_source
  import acs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Power control from the sequencer
  input wire logic analogPowerUp,
  // Input level, 1 for a full positive input
  input wire logic level,
  // Bitstream
  output logic modBit
);
  // ==========================================================================
  // Bitstream
  logic idleToggle_q;

  // An unpowered core gives no valid bits, so a toggling pattern stands in for them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idleToggle_q <= 1'b0;
    end else begin
      idleToggle_q <= ~idleToggle_q;
    end
  end

  assign modBit = analogPowerUp ? level : idleToggle_q;
endmodule : acs_mod_source
`default_nettype wire

/* adc_conversion_sequencer_tb.sv */
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  // ==========================================================================
  // Signals
  localparam int TICK_CLK = OSC_DIV * MOD_DIV;
  logic clk, arst_n, regWrite, regRead, modBit, level;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, d;
  logic analogPowerUp, negativeInputGround, temperatureSensorSelect, modulatorClock, conversionDone;
  logic [3:0] positiveConverterInput, negativeConverterInput;
  logic [2:0] fullScaleRangeSelect;
  int mismatches, checked, n;
  logic [DATA_W-1:0] lsbNv [0:7] = '{32'h002DC6C0, 32'h001E8480, 32'h000F4240, 32'h0007A120, 32'h0003D090,
                                     32'h0001E848, 32'h0001E848, 32'h0001E848};
  // Positive and negative input per select code, one-hot by input number
  logic [3:0] posSel [0:7] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [3:0] negSel [0:7] = '{4'h2, 4'h8, 4'h8, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};

  acs_sequencer dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .modBit(modBit), .analogPowerUp(analogPowerUp),
    .positiveConverterInput(positiveConverterInput), .negativeConverterInput(negativeConverterInput),
    .negativeInputGround(negativeInputGround), .temperatureSensorSelect(temperatureSensorSelect),
    .fullScaleRangeSelect(fullScaleRangeSelect), .modulatorClock(modulatorClock), .conversionDone(conversionDone));

  acs_mod_source core (.clk(clk), .arst_n(arst_n), .analogPowerUp(analogPowerUp), .level(level), .modBit(modBit));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    v = regRdData;
  endtask : rd

  // Bounded wait on a one-cycle pulse; counts edges from the call
  task automatic wait_pulse(input bit onDone, input int limit, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      #1;
      cyc++;
    end while ((onDone ? conversionDone : modulatorClock) !== 1'b1 && cyc < limit);
    if ((onDone ? conversionDone : modulatorClock) !== 1'b1) begin
      mismatches++;
      $display("BAD %s expected pulse seen none", onDone ? "conversionDone" : "modulatorClock");
      tally_and_finish();
    end
  endtask : wait_pulse

  // Requests right after a sample tick, so no tick falls before the core powers up
  task automatic start_at_tick(input logic [DATA_W-1:0] v);
    int k;
    wait_pulse(1'b0, 400, k);
    wr(OFS_CONFIG, v);
  endtask : start_at_tick

  function automatic logic [DATA_W-1:0] cfg(input logic [2:0] mux, input logic [2:0] gain, input logic mode,
                                            input logic [2:0] rate, input logic temp);
    cfg = '0;
    cfg[CFG_MUX_HI:CFG_MUX_LO] = mux;
    cfg[CFG_FSR_HI:CFG_FSR_LO] = gain;
    cfg[CFG_MODE] = mode;
    cfg[CFG_RATE_HI:CFG_RATE_LO] = rate;
    cfg[CFG_TEMP] = temp;
  endfunction : cfg

  // ==========================================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = '0;
    regWrData = '0;
    level = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    check("analogPowerUp", 32'h0, 32'(analogPowerUp));
    check("fullScaleRangeSelect", 32'h2, 32'(fullScaleRangeSelect));
    rd(OFS_CONFIG, d);
    check("config reset", cfg(MUX_RST, FSR_RST, MODE_RST, RATE_RST, TEMP_RST), d);
    rd(8'h10, d);
    check("unmapped", 32'h0, d);
    // Every range and its step size, and every input selection
    for (int g = 0; g < 8; g++) begin
      wr(OFS_CONFIG, cfg(3'(g), 3'(g), 1'b1, 3'h6, 1'b0));
      rd(OFS_LSB, d);
      check("lsb size", lsbNv[g], d);
      check("fullScaleRangeSelect", 32'(g), 32'(fullScaleRangeSelect));
      check("positive input", 32'(posSel[g]), 32'(positiveConverterInput));
      check("negative input", 32'(negSel[g]), 32'(negativeConverterInput));
      check("ground switch", 32'(g >= 4), 32'(negativeInputGround));
    end
    wait_pulse(1'b0, 400, n);
    wait_pulse(1'b0, 400, n);
    check("tick spacing", 32'(TICK_CLK), 32'(n));
    // Single-ended, negative input: clamps at zero
    level = 1'b0;
    start_at_tick(cfg(MUX_S0, 3'h2, 1'b1, 3'h6, 1'b0) | 32'h8000);
    repeat (3) @(posedge clk);
    check("positive input", 32'(SEL_IN0), 32'(positiveConverterInput));
    check("negative input", 32'(SEL_NONE), 32'(negativeConverterInput));
    check("ground switch", 32'h1, 32'(negativeInputGround));
    rd(OFS_CONFIG, d);
    check("request bit", cfg(MUX_S0, 3'h2, 1'b1, 3'h6, 1'b0), d);
    rd(OFS_STATUS, d);
    check("status busy", 32'h5, d);
    wait_pulse(1'b1, 20000, n);
    rd(OFS_STATUS, d);
    check("status done", 32'h2, d);
    rd(OFS_RESULT, d);
    check("single-ended result", 32'h0000, d);
    // Differential, full positive; a repeated request while busy is dropped
    level = 1'b1;
    start_at_tick(cfg(MUX_D01, 3'h2, 1'b1, 3'h6, 1'b0) | 32'h8000);
    repeat (3) @(posedge clk);
    check("positive input", 32'(SEL_IN0), 32'(positiveConverterInput));
    check("negative input", 32'(SEL_IN1), 32'(negativeConverterInput));
    check("ground switch", 32'h0, 32'(negativeInputGround));
    repeat (2000) @(posedge clk);
    rd(OFS_RESULT, d);
    check("result mid-run", 32'h0000, d);
    wr(OFS_CONFIG, cfg(MUX_D01, 3'h2, 1'b1, 3'h6, 1'b0) | 32'h8000);
    wait_pulse(1'b1, 20000, n);
    check("busy request ignored", 32'h1, 32'(n < int'(SAMPLES[6]) * TICK_CLK - 1000));
    rd(OFS_RESULT, d);
    check("positive full scale", 32'h7FF0, d);
    repeat (400) @(posedge clk);
    rd(OFS_STATUS, d);
    check("status idle", 32'h0, d);
    // Continuous, full negative: spacing of results follows the rate
    level = 1'b0;
    start_at_tick(cfg(MUX_D23, 3'h2, 1'b0, 3'h6, 1'b0));
    repeat (3) @(posedge clk);
    check("positive input", 32'(SEL_IN2), 32'(positiveConverterInput));
    check("negative input", 32'(SEL_IN3), 32'(negativeConverterInput));
    wait_pulse(1'b1, 20000, n);
    wait_pulse(1'b1, 20000, n);
    check("result spacing", 32'(SAMPLES[6]) * 32'(TICK_CLK), 32'(n));
    rd(OFS_RESULT, d);
    check("negative full scale", 32'h8000, d);
    check("powered between", 32'h1, 32'(analogPowerUp));
    wr(OFS_CONFIG, cfg(MUX_D23, 3'h2, 1'b1, 3'h6, 1'b0));
    wait_pulse(1'b1, 20000, n);
    repeat (5) @(posedge clk);
    check("back to single", 32'h0, 32'(analogPowerUp));
    // Temperature sensor through the same path and register
    level = 1'b1;
    start_at_tick(cfg(MUX_D01, 3'h2, 1'b1, 3'h6, 1'b1) | 32'h8000);
    repeat (3) @(posedge clk);
    check("sensor select", 32'h1, 32'(temperatureSensorSelect));
    check("negative input", 32'(SEL_NONE), 32'(negativeConverterInput));
    wait_pulse(1'b1, 20000, n);
    rd(OFS_RESULT, d);
    check("temperature word", 32'h7FF0, d);
    tally_and_finish();
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
